// File: lvm_chk_monitor.sv
// Concurrent checks on the ports of the low-voltage monitor.
`timescale 1ns/100ps
module lvm_chk (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pready,
   input  wire logic monitor_power_disable,
   input  wire logic lowvolt_reset_disable,
   input  wire logic stop_mode,
   input  wire logic wait_mode,
   input  wire logic supply_below_trip,
   input  wire logic supply_above_recovery,
   input  wire logic monitor_enable,
   input  wire logic lowvolt_reset_hold,
   input  wire logic ext_reset_pin_out,
   input  wire logic ext_reset_pin_oe,
   input  wire logic wake_request,
   input  wire logic irq
);
   // ------------------------------------------------------------
   // Single clock domain, so one clocking and one disable serve all.
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_pdis; monitor_power_disable |=> !lowvolt_reset_hold; endproperty
   a_pdis: assert property (p_pdis) else $error("reset hold while monitor off");
   property p_men; monitor_power_disable |-> !monitor_enable; endproperty
   a_men: assert property (p_men) else $error("monitor on while disabled");
   property p_rdis; lowvolt_reset_disable && !lowvolt_reset_hold |=> !lowvolt_reset_hold; endproperty
   a_rdis: assert property (p_rdis) else $error("reset raised while disabled");
   property p_trip;
      monitor_enable && supply_below_trip && !lowvolt_reset_disable |=> lowvolt_reset_hold;
   endproperty
   a_trip: assert property (p_trip) else $error("no reset on low supply");
   property p_hold;
      lowvolt_reset_hold && monitor_enable && !supply_above_recovery && !lowvolt_reset_disable
      |=> lowvolt_reset_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("reset released early");
   property p_pin; 1'b1 |-> ext_reset_pin_oe == lowvolt_reset_hold && !ext_reset_pin_out; endproperty
   a_pin: assert property (p_pin) else $error("reset pin not following hold");
   property p_wake; 1'b1 |-> wake_request == (wait_mode && lowvolt_reset_hold); endproperty
   a_wake: assert property (p_wake) else $error("wake request wrong");
   property p_wact; wait_mode && !stop_mode && !monitor_power_disable |-> monitor_enable; endproperty
   a_wact: assert property (p_wact) else $error("monitor off in wait");
   property p_irq; $rose(irq) |-> $past(pready); endproperty
   a_irq: assert property (p_irq) else $error("interrupt without bus access");
endmodule : lvm_chk

bind lvm_low_voltage_monitor lvm_chk chk_u (
   .pclk, .presetn, .pready, .monitor_power_disable, .lowvolt_reset_disable, .stop_mode,
   .wait_mode, .supply_below_trip, .supply_above_recovery, .monitor_enable,
   .lowvolt_reset_hold, .ext_reset_pin_out, .ext_reset_pin_oe, .wake_request, .irq
);

// File: lvm_defines.svh
// Register offsets, field positions and reset values of the low-voltage monitor.
`ifndef LVM_DEFINES_SVH
`define LVM_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define LVM_OFS_LVSC     8'h00
`define LVM_OFS_RSRC     8'h04
`define LVM_OFS_IRQ_STAT 8'h08
`define LVM_OFS_IRQ_MASK 8'h0C

// ------------------------------------------------------------
// Status and control field positions
// ------------------------------------------------------------
`define LVM_LVSC_LOCK    7
`define LVM_LVSC_KEEP    6
`define LVM_LVSC_DETECT  5

// ------------------------------------------------------------
// Reset-source field positions
// ------------------------------------------------------------
`define LVM_RSRC_POR     0
`define LVM_RSRC_PIN     1
`define LVM_RSRC_WDOG    2
`define LVM_RSRC_BADOP   3
`define LVM_RSRC_BADAD   4
`define LVM_RSRC_LOWV    5
`define LVM_RSRC_WIDTH   6

// ------------------------------------------------------------
// Interrupt field positions
// ------------------------------------------------------------
`define LVM_IRQ_LOCKED   0
`define LVM_IRQ_UNMAP    1
`define LVM_IRQ_WIDTH    2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LVM_RSRC_RESET   6'h01
`define LVM_RSRC_POR_VAL 6'h01
`define LVM_IRQ_RESET    2'h0

`endif

// File: lvm_low_voltage_monitor.sv
// Low-voltage monitor control logic with reset-source flags and an APB register slave.
//
// How it works
// - Power-disable option stops monitoring: no flag change, no reset.
// - Reset-disable option blocks low-voltage reset on falling supply.
// - Once triggered, low-voltage reset holds until supply above recovery level.
// - Active low-voltage reset also pulls the external reset pin low.
// - Detect flag sets below trip, clears above recovery, else holds.
// - Detect flag is read-only and cleared by any reset.
// - With the lock bit set, writes to status and control are ignored.
// - Software cannot clear the lock bit; only reset clears it.
// - In stop, monitor runs only with power enabled and keep-alive set.
// - Monitor stays active in wait; its reset wakes the device.
// - The monitor itself never raises an interrupt request.
// - Reset-source register holds one flag per reset source.
// - Power-on sets its flag and clears others; others only add.
// - Besides power-on, only a read clears reset-source flags; writes are ignored.
// - Several resets without a read leave all their flags set.
`timescale 1ns/100ps
`include "lvm_defines.svh"

module lvm_low_voltage_monitor #(
   parameter int ADDR_W = 8
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                monitor_power_disable,
   input  wire logic                lowvolt_reset_disable,
   input  wire logic                stop_mode,
   input  wire logic                wait_mode,
   input  wire logic                device_reset,
   input  wire logic                supply_below_trip,
   input  wire logic                supply_above_recovery,
   input  wire logic                por_event,
   input  wire logic                pin_reset_event,
   input  wire logic                watchdog_reset_event,
   input  wire logic                bad_opcode_reset_event,
   input  wire logic                bad_address_reset_event,
   output logic                     monitor_enable,
   output logic                     lowvolt_reset_hold,
   output logic                     ext_reset_pin_out,
   output logic                     ext_reset_pin_oe,
   output logic                     wake_request,
   output logic                     irq
);

   import lvm_pkg::*;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Full-width compare, so a misaligned address matches no register.
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] offset);
      return (addr == offset);
   endfunction : addr_hit

   // Every register is one byte wide and reads with zeros above bit 7.
   function automatic logic [31:0] byte_word(input logic [7:0] value);
      return {24'h000000, value};
   endfunction : byte_word

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   lvm_bus_state_type             bus_ff;
   lvm_bus_state_type             nxt_bus;
   logic [31:0]                   prdata_ff;
   logic [31:0]                   nxt_prdata;
   logic                          lock_ff;
   logic                          nxt_lock;
   logic                          keep_ff;
   logic                          nxt_keep;
   logic                          detect_ff;
   logic                          nxt_detect;
   logic                          lvr_ff;
   logic                          nxt_lvr;
   logic [`LVM_RSRC_WIDTH-1:0]    rsrc_ff;
   logic [`LVM_RSRC_WIDTH-1:0]    nxt_rsrc;
   logic [`LVM_IRQ_WIDTH-1:0]     istat_ff;
   logic [`LVM_IRQ_WIDTH-1:0]     nxt_istat;
   logic [`LVM_IRQ_WIDTH-1:0]     imask_ff;
   logic [`LVM_IRQ_WIDTH-1:0]     nxt_imask;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire logic                      access_phase;
   wire logic                      capture_cycle;
   wire logic                      xfer_done;
   wire logic                      wr_done;
   wire logic                      rd_done;
   wire logic                      lane0;
   wire logic                      sel_lvsc;
   wire logic                      sel_rsrc;
   wire logic                      sel_istat;
   wire logic                      sel_imask;
   wire logic                      unmapped;
   wire logic [31:0]               read_mux;
   wire logic [7:0]                lvsc_view;

   // Access is held by the master until pready, so a fixed three-cycle
   // access phase gives read data time to come from a flip-flop.
   assign access_phase  = psel & penable;
   assign capture_cycle = access_phase & (bus_ff == LVM_BUS_CAPT);
   assign xfer_done     = access_phase & (bus_ff == LVM_BUS_DONE);
   assign wr_done       = xfer_done & pwrite;
   assign rd_done       = xfer_done & ~pwrite;
   assign lane0         = pstrb[0];

   // Full address compare, so misaligned addresses fall into the unmapped set.
   assign sel_lvsc  = addr_hit(paddr, ADDR_W'(`LVM_OFS_LVSC));
   assign sel_rsrc  = addr_hit(paddr, ADDR_W'(`LVM_OFS_RSRC));
   assign sel_istat = addr_hit(paddr, ADDR_W'(`LVM_OFS_IRQ_STAT));
   assign sel_imask = addr_hit(paddr, ADDR_W'(`LVM_OFS_IRQ_MASK));
   assign unmapped  = ~(sel_lvsc | sel_rsrc | sel_istat | sel_imask);

   // Handshake outputs are combinational; an unmapped access still
   // completes, with an error, so the master never hangs.
   assign pready  = xfer_done;
   assign pslverr = xfer_done & unmapped;
   assign prdata  = prdata_ff;

   // ------------------------------------------------------------
   // Read view
   // ------------------------------------------------------------
   // Unused bit positions are tied to zero here, and every register is
   // widened to the bus word by the same helper.
   assign lvsc_view = {lock_ff, keep_ff, detect_ff, 5'h00};
   assign read_mux  = sel_lvsc  ? byte_word(lvsc_view) :
                      sel_rsrc  ? byte_word(8'(rsrc_ff)) :
                      sel_istat ? byte_word(8'(istat_ff)) :
                      sel_imask ? byte_word(8'(imask_ff)) :
                      32'h00000000;

   // ------------------------------------------------------------
   // Bus phase sequencing
   // ------------------------------------------------------------
   // Idle until an access phase, one capture cycle, then the done cycle.
   // This gives every transfer exactly two wait states.
   always_comb begin
      nxt_bus = bus_ff;
      unique case (bus_ff)
         LVM_BUS_IDLE: begin
            if (access_phase) begin
               nxt_bus = LVM_BUS_CAPT;
            end
         end
         LVM_BUS_CAPT: begin
            nxt_bus = LVM_BUS_DONE;
         end
         LVM_BUS_DONE: begin
            nxt_bus = LVM_BUS_IDLE;
         end
         // The unused code drops straight back to idle.
         default: begin
            nxt_bus = LVM_BUS_IDLE;
         end
      endcase
   end

   // Read data is latched in the capture cycle and held to the next read.
   assign nxt_prdata = (capture_cycle & ~pwrite) ? read_mux : prdata_ff;

   // ------------------------------------------------------------
   // Status and control register
   // ------------------------------------------------------------
   wire logic                      lvsc_write;
   wire logic                      locked_write;

   // A write only lands while unlocked; the detect bit is never written.
   assign lvsc_write   = wr_done & sel_lvsc & lane0 & ~lock_ff;
   assign locked_write = wr_done & sel_lvsc & lock_ff;

   // Lock can only be raised by software; reset is the sole way down.
   assign nxt_lock = device_reset ? 1'b0 :
                     (lock_ff | (lvsc_write & pwdata[`LVM_LVSC_LOCK]));

   // Keep-alive follows the last unlocked write and clears on reset.
   assign nxt_keep = device_reset ? 1'b0 :
                     lvsc_write   ? pwdata[`LVM_LVSC_KEEP] : keep_ff;

   // ------------------------------------------------------------
   // Monitor enable and detect flag
   // ------------------------------------------------------------
   wire logic                      stop_off;
   wire logic                      monitor_active;

   // Stop mode gates the monitor unless keep-alive is set; wait mode does
   // not gate it at all. Keeping it alive in stop costs supply current.
   assign stop_off       = stop_mode & ~keep_ff;
   assign monitor_active = ~monitor_power_disable & ~stop_off;
   assign monitor_enable = monitor_active;

   // Hysteresis: between the two levels neither comparator input is set.
   always_comb begin
      nxt_detect = detect_ff;
      if (device_reset) begin
         nxt_detect = 1'b0;
      end else if (!monitor_active) begin
         nxt_detect = detect_ff;
      end else if (supply_below_trip) begin
         nxt_detect = 1'b1;
      end else if (supply_above_recovery) begin
         nxt_detect = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Low-voltage reset
   // ------------------------------------------------------------
   wire logic                      lvr_rise;

   // Once held, only a recovered supply releases the reset; the power
   // disable option withdraws it because the monitor is then blind.
   // An unpowered comparator may chatter, so only an active monitor's
   // recovery report may release a held reset.
   always_comb begin
      nxt_lvr = lvr_ff;
      if (monitor_power_disable) begin
         nxt_lvr = 1'b0;
      end else if (lvr_ff) begin
         nxt_lvr = ~(monitor_active & supply_above_recovery);
      end else begin
         nxt_lvr = monitor_active & ~lowvolt_reset_disable & supply_below_trip;
      end
   end

   assign lvr_rise = nxt_lvr & ~lvr_ff;

   // The pin is open drain: it only ever drives low.
   assign lowvolt_reset_hold = lvr_ff;
   assign ext_reset_pin_out  = 1'b0;
   assign ext_reset_pin_oe   = lvr_ff;
   assign wake_request       = lvr_ff & wait_mode;

   // ------------------------------------------------------------
   // Reset-source flags
   // ------------------------------------------------------------
   wire logic [`LVM_RSRC_WIDTH-1:0] rsrc_set;
   wire logic [`LVM_RSRC_WIDTH-1:0] rsrc_clr;

   // Each source but power-on sets only its own flag and never clears the others.
   // The power-on flag comes from the override below, not from a set.
   assign rsrc_set[`LVM_RSRC_POR]   = 1'b0;
   assign rsrc_set[`LVM_RSRC_PIN]   = pin_reset_event;
   assign rsrc_set[`LVM_RSRC_WDOG]  = watchdog_reset_event;
   assign rsrc_set[`LVM_RSRC_BADOP] = bad_opcode_reset_event;
   assign rsrc_set[`LVM_RSRC_BADAD] = bad_address_reset_event;
   assign rsrc_set[`LVM_RSRC_LOWV]  = lvr_rise;

   // A read clears only the bits it actually returned, so a flag that
   // rises after capture survives to the next read. Writes do nothing.
   assign rsrc_clr = (rd_done & sel_rsrc) ?
                     prdata_ff[`LVM_RSRC_WIDTH-1:0] : {`LVM_RSRC_WIDTH{1'b0}};

   // Set wins over a clear in the same cycle; flags accumulate until read.
   assign nxt_rsrc = por_event ? `LVM_RSRC_POR_VAL :
                     ((rsrc_ff & ~rsrc_clr) | rsrc_set);

   // ------------------------------------------------------------
   // Bus interrupt status and mask
   // ------------------------------------------------------------
   wire logic [`LVM_IRQ_WIDTH-1:0]  irq_event;
   wire logic [`LVM_IRQ_WIDTH-1:0]  irq_w1c;

   // Only bus misuse is reported; supply events never reach this output.
   assign irq_event[`LVM_IRQ_LOCKED] = locked_write;
   assign irq_event[`LVM_IRQ_UNMAP]  = xfer_done & unmapped;

   // Write one to clear; an event in the same cycle wins over the clear.
   assign irq_w1c   = (wr_done & sel_istat & lane0) ?
                      pwdata[`LVM_IRQ_WIDTH-1:0] : {`LVM_IRQ_WIDTH{1'b0}};
   assign nxt_istat = (istat_ff & ~irq_w1c) | irq_event;
   // The mask gates only the output; status bits still collect events.
   assign nxt_imask = (wr_done & sel_imask & lane0) ?
                      pwdata[`LVM_IRQ_WIDTH-1:0] : imask_ff;
   assign irq       = |(istat_ff & imask_ff);

   // ------------------------------------------------------------
   // Flip-flops
   // ------------------------------------------------------------
   // Bus slave state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_ff    <= LVM_BUS_IDLE;
         prdata_ff <= 32'h00000000;
      end else begin
         bus_ff    <= nxt_bus;
         prdata_ff <= nxt_prdata;
      end
   end

   // Monitor control and status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_ff   <= 1'b0;
         keep_ff   <= 1'b0;
         detect_ff <= 1'b0;
         lvr_ff    <= 1'b0;
      end else begin
         lock_ff   <= nxt_lock;
         keep_ff   <= nxt_keep;
         detect_ff <= nxt_detect;
         lvr_ff    <= nxt_lvr;
      end
   end

   // Power-on reset leaves only the power-on flag standing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsrc_ff <= `LVM_RSRC_RESET;
      end else begin
         rsrc_ff <= nxt_rsrc;
      end
   end

   // Interrupt status and mask.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_ff <= `LVM_IRQ_RESET;
         imask_ff <= `LVM_IRQ_RESET;
      end else begin
         istat_ff <= nxt_istat;
         imask_ff <= nxt_imask;
      end
   end

endmodule : lvm_low_voltage_monitor

// File: lvm_pkg.sv
// Types shared by the low-voltage monitor design.
package lvm_pkg;

   // ------------------------------------------------------------
   // Bus slave phase, Gray coded from idle through capture to done; the return from done to idle flips both bits.
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LVM_BUS_IDLE = 2'b00,
      LVM_BUS_CAPT = 2'b01,
      LVM_BUS_DONE = 2'b11
   } lvm_bus_state_type;

endpackage : lvm_pkg

// File: lvm_supply_model.sv
// Partner model: supply comparator and system reset logic.
`timescale 1ns/100ps
module lvm_supply_model (
   input  wire logic       pclk,
   input  wire logic [1:0] vdd,
   input  wire logic       monitor_enable,
   input  wire logic       lowvolt_reset_hold,
   input  wire logic       sys_reset_req,
   output logic            supply_below_trip,
   output logic            supply_above_recovery,
   output logic            device_reset
);
   logic noise_ff = 1'b0;

   // An unpowered comparator gives no trustworthy answer, so it chatters.
   always_ff @(posedge pclk) begin
      noise_ff <= ~noise_ff;
   end

   // Level 0 is below the trip level, 1 between the levels, 2 above recovery.
   assign supply_below_trip     = monitor_enable ? (vdd == 2'h0) : noise_ff;
   assign supply_above_recovery = monitor_enable ? (vdd == 2'h2) : ~noise_ff;
   // The system stays in reset while the monitor holds it.
   assign device_reset          = lowvolt_reset_hold | sys_reset_req;
endmodule : lvm_supply_model

// File: tb_top.sv
// Self-checking testbench of the low-voltage monitor with an APB master.
`timescale 1ns/100ps
`include "lvm_defines.svh"
module tb_top;
   import lvm_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic [6:0]  ctl = 7'h02; // Sys reset, stop, wait, reset off, power off, supply level.
   logic [4:0]  ev = 5'h00;
   logic [31:0] prdata;
   logic        pready, pslverr, slv_err, monitor_enable, lowvolt_reset_hold;
   logic        ext_reset_pin_out, ext_reset_pin_oe, wake_request, irq, device_reset;
   logic        supply_below_trip, supply_above_recovery;
   int          errors = 0;
   int          comparisons = 0;

   lvm_low_voltage_monitor dut_u (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .monitor_power_disable(ctl[2]), .lowvolt_reset_disable(ctl[3]),
      .stop_mode(ctl[5]), .wait_mode(ctl[4]), .device_reset, .supply_below_trip,
      .supply_above_recovery, .por_event(ev[0]), .pin_reset_event(ev[1]),
      .watchdog_reset_event(ev[2]), .bad_opcode_reset_event(ev[3]),
      .bad_address_reset_event(ev[4]), .monitor_enable, .lowvolt_reset_hold,
      .ext_reset_pin_out, .ext_reset_pin_oe, .wake_request, .irq
   );
   lvm_supply_model sup_u (
      .pclk, .vdd(ctl[1:0]), .monitor_enable, .lowvolt_reset_hold, .sys_reset_req(ctl[6]),
      .supply_below_trip, .supply_above_recovery, .device_reset
   );

   // Clock of 20 ns period.
   always #10 pclk = ~pclk;

   // ------------------------------------------------------------
   // Compare and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic pin(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : pin

   // The wait is bounded so a stuck slave shows up as a mismatch, not a hang.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      pin(pready, 1'b1);
      r = prdata;
      slv_err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr

   // Side inputs change at a rising edge; outputs are looked at on the falling one.
   task automatic go(input logic [6:0] v, input int n);
      @(posedge pclk);
      ctl <= v;
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : go

   task automatic pulse(input logic [4:0] v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 5'h00;
   endtask : pulse

   task automatic test_done();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_polled();
      rd(`LVM_OFS_LVSC, 32'h0);
      rd(`LVM_OFS_RSRC, 32'h01);
      rd(`LVM_OFS_RSRC, 32'h0);
      go(7'h08, 2);
      pin(lowvolt_reset_hold, 1'b0);
      rd(`LVM_OFS_LVSC, 32'h20);
      wr(`LVM_OFS_LVSC, 32'h0);
      rd(`LVM_OFS_LVSC, 32'h20);
      go(7'h09, 2);
      rd(`LVM_OFS_LVSC, 32'h20);
      go(7'h0A, 2);
      rd(`LVM_OFS_LVSC, 32'h0);
      go(7'h04, 3);
      pin(monitor_enable, 1'b0);
      pin(lowvolt_reset_hold, 1'b0);
      rd(`LVM_OFS_LVSC, 32'h0);
      rd(`LVM_OFS_RSRC, 32'h0);
   endtask : t_polled

   task automatic t_forced();
      go(7'h10, 2);
      pin(lowvolt_reset_hold, 1'b1);
      pin(ext_reset_pin_oe, 1'b1);
      pin(wake_request, 1'b1);
      pin(ext_reset_pin_out, 1'b0);
      go(7'h11, 4);
      pin(lowvolt_reset_hold, 1'b1);
      go(7'h12, 2);
      pin(lowvolt_reset_hold, 1'b0);
      pin(irq, 1'b0);
      go(7'h02, 0);
      rd(`LVM_OFS_RSRC, 32'h20);
      for (int i = 1; i < 5; i++) pulse(5'h01 << i);
      rd(`LVM_OFS_RSRC, 32'h1E);
      pulse(5'h02);
      wr(`LVM_OFS_RSRC, 32'h0);
      rd(`LVM_OFS_RSRC, 32'h02);
      pulse(5'h04);
      pulse(5'h01);
      rd(`LVM_OFS_RSRC, 32'h01);
   endtask : t_forced

   task automatic t_lock();
      logic [31:0] r;
      wr(`LVM_OFS_LVSC, 32'h40);
      go(7'h22, 0);
      pin(monitor_enable, 1'b1);
      @(posedge pclk);
      pstrb <= 4'hE;
      wr(`LVM_OFS_LVSC, 32'hFF);
      pstrb <= 4'hF;
      rd(`LVM_OFS_LVSC, 32'h40);
      wr(`LVM_OFS_LVSC, 32'hFF);
      rd(`LVM_OFS_LVSC, 32'hC0);
      wr(`LVM_OFS_LVSC, 32'h0);
      rd(`LVM_OFS_LVSC, 32'hC0);
      rd(`LVM_OFS_IRQ_STAT, 32'h01);
      wr(`LVM_OFS_IRQ_MASK, 32'h3);
      apb(1'b0, 8'h10, 32'h0, r);
      pin(slv_err, 1'b1);
      chk(r, 32'h0);
      @(negedge pclk);
      pin(irq, 1'b1);
      wr(`LVM_OFS_IRQ_STAT, 32'h3);
      @(negedge pclk);
      pin(irq, 1'b0);
      go(7'h62, 1);
      go(7'h22, 0);
      pin(monitor_enable, 1'b0);
      rd(`LVM_OFS_LVSC, 32'h0);
   endtask : t_lock

   // Main sequence: reset for 8 cycles, then the scenarios in turn.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_polled();
      t_forced();
      t_lock();
      test_done();
   end

   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      test_done();
   end
endmodule : tb_top
